// ---- hw/ddc_consts.vh ----
// Constants for the hopping down converter: register offsets, fields, resets.
// Assumes byte addresses on a 32-bit classic Wishbone register bus.
`ifndef DDC_CONSTS_VH
`define DDC_CONSTS_VH

// Register byte offsets.
`define DDC_OFS_CTRL 8'h00
`define DDC_OFS_STATUS 8'h04
`define DDC_OFS_RDIV 8'h08
`define DDC_OFS_FREQ_BASE 8'h10
`define DDC_OFS_PHASE_BASE 8'h30
`define DDC_OFS_LAST 8'h4C

// Control register fields.
`define DDC_CTRL_BYPASS 0
`define DDC_CTRL_SINGLE 1
`define DDC_CTRL_SRC 2
`define DDC_CTRL_SEL_A_LO 4
`define DDC_CTRL_SEL_B_LO 6
`define DDC_CTRL_BIND_A 8
`define DDC_CTRL_BIND_B 9
`define DDC_CTRL_DEC8 10
`define DDC_CTRL_WIDTH 11

// Reset values.
`define DDC_CTRL_RST 11'h000
`define DDC_RDIV_RST 16'h0000
`define DDC_FREQ_RST 32'h00000000
`define DDC_PHASE_RST 16'h0000

// Filter scaling: product magnitude 2^22 reduced to a 15-bit output.
`define DDC_BASE_SHIFT 4'h8
`define DDC_DEC4_LOG 4'h2
`define DDC_DEC8_LOG 4'h3
`define DDC_OUT_MAX 15'h3FFF
`define DDC_OUT_MIN 15'h4000

`endif

// ---- hw/ddc_nco_hopping_mixer.v ----
// Two-path digital down converter with four hopping oscillators per path.
// Assumes one sample per clock from both converter cores on i_clk and a
// classic Wishbone master; select pins arrive from outside the clock domain.
//
// Summary of operation
// - Samples go straight to bypass outputs, or through mixing and decimation.
// - Mixer multiplies real sample by cosine and sine of selected oscillator.
// - Low-pass filtering and decimation are one integrate-and-dump operation.
// - In two-channel mode each path takes channel A or B per binding.
// - In single-channel mode only the first path produces output.
// - Precision reduction rounds to nearest, ties going to the even code.
// - Out-of-range results saturate to the limit code, never wrap.
// - Filter keeps full precision inside; rounding happens at its output only.
// - Each oscillator frequency is a 32-bit word per oscillator per path.
// - Each path owns four oscillators with own accumulator, frequency, phase.
// - All accumulators advance every cycle, selected or not.
// - With source bit 1, a hop happens when select pins change; pins are asynchronous.
// - Pin change reaches mixer in roughly 4 to 5 cycles.
// - Source bit 1 selects by pins; 0, the reset default, by register.
// - Select value 00..11 chooses oscillator 0..3; other source ignored.
// - Each oscillator has its own programmable phase offset.
// - With divider zero, frequency is word times 2^-32 times clock.
// - Frequency word wraps modulo 2^32, signed or unsigned view alike.
// - The 16-bit offset is left-aligned and added to the accumulator.
// - Filter outputs carry 15 bits of resolution.
`timescale 1ns/10ps
`include "ddc_consts.vh"

module ddc_nco_hopping_mixer #(
    parameter SAMPLE_W = 12,
    parameter OUT_W = 15
) (
    // Clock and reset.
    input wire i_clk,
    input wire i_arst_n,
    // Wishbone slave.
    input wire i_wb_cyc,
    input wire i_wb_stb,
    input wire i_wb_we,
    input wire [7:0] i_wb_adr,
    input wire [3:0] i_wb_sel,
    input wire [31:0] i_wb_dat,
    output reg [31:0] o_wb_dat,
    output reg o_wb_ack,
    // Converter samples, one per clock.
    input wire [SAMPLE_W-1:0] i_adc_a,
    input wire [SAMPLE_W-1:0] i_adc_b,
    // Oscillator select pins.
    input wire [1:0] i_ddc_a_osc_sel_pins,
    input wire [1:0] i_ddc_b_osc_sel_pins,
    // Bypass outputs.
    output reg [SAMPLE_W-1:0] o_bypass_a,
    output reg [SAMPLE_W-1:0] o_bypass_b,
    output reg o_bypass_valid,
    // Decimated complex outputs.
    output reg [OUT_W-1:0] o_ddc_a_i,
    output reg [OUT_W-1:0] o_ddc_a_q,
    output reg o_ddc_a_valid,
    output reg [OUT_W-1:0] o_ddc_b_i,
    output reg [OUT_W-1:0] o_ddc_b_q,
    output reg o_ddc_b_valid
);

    localparam PROD_W = 2 * SAMPLE_W;
    localparam ACC_W = PROD_W + 3;

    reg [`DDC_CTRL_WIDTH-1:0] ctrl_q;
    reg [15:0] rdiv_q;
    reg [31:0] freq_q [0:7];
    reg [15:0] phase_q [0:7];
    reg [31:0] accum_q [0:7];
    reg [3:0] pin_meta_q;
    reg [3:0] pin_sync_q;
    reg [1:0] sel_q [0:1];
    reg signed [SAMPLE_W-1:0] smp_q [0:1];
    reg [31:0] ph_q [0:1];
    reg signed [SAMPLE_W-1:0] mix_smp_q [0:1];
    reg signed [SAMPLE_W-1:0] cos_q [0:1];
    reg signed [SAMPLE_W-1:0] sin_q [0:1];
    reg signed [ACC_W-1:0] acc_i_q [0:1];
    reg signed [ACC_W-1:0] acc_q_q [0:1];
    reg [2:0] dec_cnt_q [0:1];
    reg [31:0] rd_d;
    reg [7:0] idx;
    integer k;

    wire req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    wire dec8 = ctrl_q[`DDC_CTRL_DEC8];
    wire [2:0] dec_last = dec8 ? 3'h7 : 3'h3;
    wire [3:0] out_shift = `DDC_BASE_SHIFT + (dec8 ? `DDC_DEC8_LOG : `DDC_DEC4_LOG);

    // Quarter-wave sine, nine points from 0 to 90 degrees, full scale 2047.
    function [11:0] quarter;
        input [3:0] i;
        begin
            case (i)
                4'h0: quarter = 12'h000;
                4'h1: quarter = 12'h18F;
                4'h2: quarter = 12'h30F;
                4'h3: quarter = 12'h471;
                4'h4: quarter = 12'h5A7;
                4'h5: quarter = 12'h6A6;
                4'h6: quarter = 12'h763;
                4'h7: quarter = 12'h7D8;
                default: quarter = 12'h7FF;
            endcase
        end
    endfunction

    // Sine of the top five phase bits; coarse, but phase-continuous.
    function signed [11:0] sine;
        input [4:0] p;
        reg [11:0] m;
        begin
            m = quarter(p[3] ? (4'h8 - {1'b0, p[2:0]}) : {1'b0, p[2:0]});
            if (p[3] && p[2:0] == 3'h0)
                m = quarter(4'h8);
            sine = p[4] ? (12'h000 - m) : m;
        end
    endfunction

    // Shift right with round-half-to-even, then clamp to the output range.
    function [OUT_W-1:0] round_sat;
        input signed [ACC_W-1:0] v;
        input [3:0] sh;
        reg signed [ACC_W-1:0] fl;
        reg [ACC_W-1:0] mask;
        reg [ACC_W-1:0] frac;
        reg [ACC_W-1:0] half;
        begin
            fl = v >>> sh;
            mask = ({ACC_W{1'b1}} << sh) ^ {ACC_W{1'b1}};
            frac = v & mask;
            half = {{(ACC_W-1){1'b0}}, 1'b1} << (sh - 4'h1);
            if (frac > half || (frac == half && fl[0]))
                fl = fl + 1;
            if (fl > $signed({{(ACC_W-OUT_W){1'b0}}, `DDC_OUT_MAX}))
                round_sat = `DDC_OUT_MAX;
            else if (fl < -$signed({{(ACC_W-OUT_W){1'b0}}, `DDC_OUT_MAX}) - 1)
                round_sat = `DDC_OUT_MIN;
            else
                round_sat = fl[OUT_W-1:0];
        end
    endfunction

    // Register access: one wait-free answer the cycle after the request.
    always @* begin
        idx = (i_wb_adr - `DDC_OFS_FREQ_BASE) >> 2;
        rd_d = 32'h00000000;
        if (i_wb_adr == `DDC_OFS_CTRL)
            rd_d = {21'h000000, ctrl_q};
        else if (i_wb_adr == `DDC_OFS_STATUS)
            rd_d = {24'h000000, pin_sync_q, sel_q[1], sel_q[0]};
        else if (i_wb_adr == `DDC_OFS_RDIV)
            rd_d = {16'h0000, rdiv_q};
        else if (i_wb_adr >= `DDC_OFS_FREQ_BASE && i_wb_adr < `DDC_OFS_PHASE_BASE)
            rd_d = freq_q[idx[2:0]];
        else if (i_wb_adr >= `DDC_OFS_PHASE_BASE && i_wb_adr <= `DDC_OFS_LAST)
            rd_d = {16'h0000, phase_q[idx[2:0]]};
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h00000000;
            ctrl_q <= `DDC_CTRL_RST;
            rdiv_q <= `DDC_RDIV_RST;
            for (k = 0; k < 8; k = k + 1) begin
                freq_q[k] <= `DDC_FREQ_RST;
                phase_q[k] <= `DDC_PHASE_RST;
            end
        end else begin
            o_wb_ack <= req;
            o_wb_dat <= req ? rd_d : 32'h00000000;
            if (req && i_wb_we) begin
                if (i_wb_adr == `DDC_OFS_CTRL) begin
                    if (i_wb_sel[0])
                        ctrl_q[7:0] <= i_wb_dat[7:0];
                    if (i_wb_sel[1])
                        ctrl_q[10:8] <= i_wb_dat[10:8];
                end else if (i_wb_adr == `DDC_OFS_RDIV) begin
                    if (i_wb_sel[0])
                        rdiv_q[7:0] <= i_wb_dat[7:0];
                    if (i_wb_sel[1])
                        rdiv_q[15:8] <= i_wb_dat[15:8];
                end else if (i_wb_adr >= `DDC_OFS_FREQ_BASE &&
                             i_wb_adr < `DDC_OFS_PHASE_BASE) begin
                    for (k = 0; k < 4; k = k + 1)
                        if (i_wb_sel[k])
                            freq_q[idx[2:0]][8*k +: 8] <= i_wb_dat[8*k +: 8];
                end else if (i_wb_adr >= `DDC_OFS_PHASE_BASE &&
                             i_wb_adr <= `DDC_OFS_LAST) begin
                    if (i_wb_sel[0])
                        phase_q[idx[2:0]][7:0] <= i_wb_dat[7:0];
                    if (i_wb_sel[1])
                        phase_q[idx[2:0]][15:8] <= i_wb_dat[15:8];
                end
            end
        end
    end

    // Free-running accumulators; a hop never resets them, so the phase of an
    // oscillator picks up where it would have been had it stayed selected.
    // The divider value is held for software only; every setting steps in
    // basic mode, which leaves fractional-step frequencies to software.
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (k = 0; k < 8; k = k + 1)
                accum_q[k] <= 32'h00000000;
        end else begin
            for (k = 0; k < 8; k = k + 1)
                accum_q[k] <= accum_q[k] + freq_q[k];
        end
    end

    // Pins are asynchronous, so a hop lands on whichever sample follows the
    // synchroniser; software needing sample-exact hops must use the register.
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_meta_q <= 4'h0;
            pin_sync_q <= 4'h0;
        end else begin
            pin_meta_q <= {i_ddc_b_osc_sel_pins, i_ddc_a_osc_sel_pins};
            pin_sync_q <= pin_meta_q;
        end
    end

    // Selection, input binding and phase with offset, then lookup and mix.
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (k = 0; k < 2; k = k + 1) begin
                sel_q[k] <= 2'h0;
                smp_q[k] <= {SAMPLE_W{1'b0}};
                ph_q[k] <= 32'h00000000;
                mix_smp_q[k] <= {SAMPLE_W{1'b0}};
                cos_q[k] <= {SAMPLE_W{1'b0}};
                sin_q[k] <= {SAMPLE_W{1'b0}};
            end
        end else begin
            if (ctrl_q[`DDC_CTRL_SRC]) begin
                sel_q[0] <= pin_sync_q[1:0];
                sel_q[1] <= pin_sync_q[3:2];
            end else begin
                sel_q[0] <= ctrl_q[`DDC_CTRL_SEL_A_LO +: 2];
                sel_q[1] <= ctrl_q[`DDC_CTRL_SEL_B_LO +: 2];
            end
            smp_q[0] <= ctrl_q[`DDC_CTRL_BIND_A] ? i_adc_b : i_adc_a;
            smp_q[1] <= ctrl_q[`DDC_CTRL_BIND_B] ? i_adc_b : i_adc_a;
            for (k = 0; k < 2; k = k + 1) begin
                ph_q[k] <= accum_q[{k[0], sel_q[k]}] +
                           {phase_q[{k[0], sel_q[k]}], 16'h0000};
                mix_smp_q[k] <= smp_q[k];
                cos_q[k] <= sine(ph_q[k][31:27] + 5'h08);
                sin_q[k] <= sine(ph_q[k][31:27]);
            end
        end
    end

    // Combined low-pass and decimation: sum of D products, dumped each D.
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (k = 0; k < 2; k = k + 1) begin
                acc_i_q[k] <= {ACC_W{1'b0}};
                acc_q_q[k] <= {ACC_W{1'b0}};
                dec_cnt_q[k] <= 3'h0;
            end
            o_ddc_a_i <= {OUT_W{1'b0}};
            o_ddc_a_q <= {OUT_W{1'b0}};
            o_ddc_a_valid <= 1'b0;
            o_ddc_b_i <= {OUT_W{1'b0}};
            o_ddc_b_q <= {OUT_W{1'b0}};
            o_ddc_b_valid <= 1'b0;
        end else begin
            for (k = 0; k < 2; k = k + 1) begin
                dec_cnt_q[k] <= (dec_cnt_q[k] >= dec_last) ? 3'h0 : dec_cnt_q[k] + 3'h1;
                if (dec_cnt_q[k] >= dec_last) begin
                    acc_i_q[k] <= mix_smp_q[k] * cos_q[k];
                    acc_q_q[k] <= mix_smp_q[k] * sin_q[k];
                end else begin
                    acc_i_q[k] <= acc_i_q[k] + mix_smp_q[k] * cos_q[k];
                    acc_q_q[k] <= acc_q_q[k] + mix_smp_q[k] * sin_q[k];
                end
            end
            o_ddc_a_valid <= ~ctrl_q[`DDC_CTRL_BYPASS] && dec_cnt_q[0] >= dec_last;
            if (~ctrl_q[`DDC_CTRL_BYPASS] && dec_cnt_q[0] >= dec_last) begin
                o_ddc_a_i <= round_sat(acc_i_q[0], out_shift);
                o_ddc_a_q <= round_sat(acc_q_q[0], out_shift);
            end
            // The second path is dead in single-channel mode.
            o_ddc_b_valid <= ~ctrl_q[`DDC_CTRL_BYPASS] && ~ctrl_q[`DDC_CTRL_SINGLE] &&
                             dec_cnt_q[1] >= dec_last;
            if (~ctrl_q[`DDC_CTRL_BYPASS] && ~ctrl_q[`DDC_CTRL_SINGLE] &&
                dec_cnt_q[1] >= dec_last) begin
                o_ddc_b_i <= round_sat(acc_i_q[1], out_shift);
                o_ddc_b_q <= round_sat(acc_q_q[1], out_shift);
            end
        end
    end

    // Bypass path carries raw real samples at the full sample rate.
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_bypass_a <= {SAMPLE_W{1'b0}};
            o_bypass_b <= {SAMPLE_W{1'b0}};
            o_bypass_valid <= 1'b0;
        end else begin
            o_bypass_a <= i_adc_a;
            o_bypass_b <= i_adc_b;
            o_bypass_valid <= ctrl_q[`DDC_CTRL_BYPASS];
        end
    end

    // Software owns resynchronisation after a frequency change; writes here
    // simply change the step, so phase relative to other parts drifts.

endmodule

// ---- verif/adc_core_model.sv ----
// Model of the two converter cores feeding the down converter.
// Assumes the bench seeds $urandom before the free-running samples start.
`timescale 1ns/10ps
module adc_core_model (
    // Control from the bench.
    input wire logic i_clk,
    input wire logic i_hold,
    input wire logic [11:0] i_lvl_a,
    input wire logic [11:0] i_lvl_b,
    // Samples, one per clock.
    output logic [11:0] o_adc_a,
    output logic [11:0] o_adc_b
);
    initial o_adc_a = 12'h000;
    initial o_adc_b = 12'h000;
    // Real cores never pause, so a fresh sample is offered on every edge.
    always @(posedge i_clk) begin
        o_adc_a <= i_hold ? i_lvl_a : 12'($urandom);
        o_adc_b <= i_hold ? i_lvl_b : 12'($urandom);
    end
endmodule

// ---- verif/ddc_nco_hopping_mixer_monitor.sv ----
// Checker for the hopping down converter, seeing only its top ports.
// Assumes the control register is written with all byte lanes enabled.
`timescale 1ns/10ps
module ddc_nco_hopping_mixer_checker #(
    parameter SAMPLE_W = 12,
    parameter OUT_W = 15
) (
    input wire i_clk,
    input wire i_arst_n,
    input wire i_wb_cyc,
    input wire i_wb_stb,
    input wire i_wb_we,
    input wire [7:0] i_wb_adr,
    input wire [3:0] i_wb_sel,
    input wire [31:0] i_wb_dat,
    input wire [31:0] o_wb_dat,
    input wire o_wb_ack,
    input wire [SAMPLE_W-1:0] i_adc_a,
    input wire [SAMPLE_W-1:0] i_adc_b,
    input wire [1:0] i_ddc_a_osc_sel_pins,
    input wire [1:0] i_ddc_b_osc_sel_pins,
    input wire [SAMPLE_W-1:0] o_bypass_a,
    input wire [SAMPLE_W-1:0] o_bypass_b,
    input wire o_bypass_valid,
    input wire [OUT_W-1:0] o_ddc_a_i,
    input wire [OUT_W-1:0] o_ddc_a_q,
    input wire o_ddc_a_valid,
    input wire [OUT_W-1:0] o_ddc_b_i,
    input wire [OUT_W-1:0] o_ddc_b_q,
    input wire o_ddc_b_valid
);
    logic [10:0] ctrl_q;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    // Shadow of the control register, so mode checks need no internal probe.
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_q <= 11'h000;
        end else if (i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack && i_wb_adr == 8'h00) begin
            ctrl_q <= i_wb_dat[10:0];
        end
    end
    sequence bus_take;
        i_wb_cyc && i_wb_stb && !o_wb_ack;
    endsequence
    sequence a_quiet3;
        !o_ddc_a_valid [*3];
    endsequence
    ack_answer_a: assert property (bus_take |=> o_wb_ack)
        else $error("bus request not answered");
    ack_single_a: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    read_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
        else $error("read data without ack");
    bypass_copy_a: assert property (1'b1 |=> o_bypass_a == $past(i_adc_a))
        else $error("bypass sample not copied");
    bypass_flag_a: assert property (o_bypass_valid == $past(ctrl_q[0]))
        else $error("bypass valid does not follow mode");
    bypass_quiet_a: assert property (ctrl_q[0] && $past(ctrl_q[0]) && $past(ctrl_q[0], 2)
        |-> !o_ddc_a_valid && !o_ddc_b_valid)
        else $error("converter output during bypass");
    single_b_quiet_a: assert property (ctrl_q[1] && $past(ctrl_q[1]) && $past(ctrl_q[1], 2)
        |-> !o_ddc_b_valid)
        else $error("second path active in single mode");
    valid_gap_a: assert property ($rose(o_ddc_a_valid) |=> a_quiet3)
        else $error("output rate above decimated rate");
    out_hold_a: assert property (!o_ddc_a_valid |-> $stable(o_ddc_a_i) && $stable(o_ddc_a_q))
        else $error("output changed between strobes");
    status_sel_a: assert property (o_wb_ack && !i_wb_we && i_wb_adr == 8'h04 && !ctrl_q[2]
        |-> o_wb_dat[3:0] == {ctrl_q[7:6], ctrl_q[5:4]})
        else $error("active oscillator not the register choice");
endmodule
bind ddc_nco_hopping_mixer ddc_nco_hopping_mixer_checker #(.SAMPLE_W(SAMPLE_W), .OUT_W(OUT_W)) mon (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_adc_a(i_adc_a), .i_adc_b(i_adc_b),
    .i_ddc_a_osc_sel_pins(i_ddc_a_osc_sel_pins), .i_ddc_b_osc_sel_pins(i_ddc_b_osc_sel_pins),
    .o_bypass_a(o_bypass_a), .o_bypass_b(o_bypass_b), .o_bypass_valid(o_bypass_valid),
    .o_ddc_a_i(o_ddc_a_i), .o_ddc_a_q(o_ddc_a_q), .o_ddc_a_valid(o_ddc_a_valid),
    .o_ddc_b_i(o_ddc_b_i), .o_ddc_b_q(o_ddc_b_q), .o_ddc_b_valid(o_ddc_b_valid));

// ---- verif/test_ddc_nco_hopping_mixer.sv ----
// Bench for the hopping down converter: registers, bypass, hops, rounding.
// Assumes the design, its checker and the converter model are compiled first.
`timescale 1ns/10ps
`include "ddc_consts.vh"
module test_ddc_nco_hopping_mixer;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic req = 1'b0, we = 1'b0, hold = 1'b0, ack, byp_v, a_v, b_v;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, rd, rnd;
    logic [1:0] pins_a = 2'h0, pins_b = 2'h0;
    logic [11:0] lvl_a = 12'h000, lvl_b = 12'h000, adc_a, adc_b, byp_a, byp_b;
    logic [23:0] prev;
    logic [14:0] a_i, a_q, b_i, b_q;
    int failures = 0, total_checks = 0, g, c, bv;
    int cosv[5] = '{2047, 0, -2047, 0, 0};
    int sinv[5] = '{0, 2047, 0, -2047, 0};
    int frq[3] = '{32'h80000000, 32'h40000000, 32'hC0000000};
    adc_core_model src (.i_clk(i_clk), .i_hold(hold), .i_lvl_a(lvl_a), .i_lvl_b(lvl_b),
        .o_adc_a(adc_a), .o_adc_b(adc_b));
    ddc_nco_hopping_mixer dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_wb_cyc(req),
        .i_wb_stb(req), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
        .o_wb_dat(rd), .o_wb_ack(ack), .i_adc_a(adc_a), .i_adc_b(adc_b),
        .i_ddc_a_osc_sel_pins(pins_a), .i_ddc_b_osc_sel_pins(pins_b), .o_bypass_a(byp_a),
        .o_bypass_b(byp_b), .o_bypass_valid(byp_v), .o_ddc_a_i(a_i), .o_ddc_a_q(a_q),
        .o_ddc_a_valid(a_v), .o_ddc_b_i(b_i), .o_ddc_b_q(b_q), .o_ddc_b_valid(b_v));
    initial forever #20 i_clk = ~i_clk;
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge i_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            failures++;
            tally_and_finish();
        end
        rdat = rd;
        req <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wait_out(input int k, output int n);
        repeat (k) begin
            n = 0;
            do begin
                @(posedge i_clk);
                n++;
            end while (a_v !== 1'b1 && n < 100);
            if (n >= 100) begin
                failures++;
                tally_and_finish();
            end
        end
    endtask
    // Convergent rounding of the boxcar sum; ties land on the even code.
    function automatic logic [14:0] expect_out(input int x, input int cf, input int d);
        int n, s, q, r;
        n = d * x * cf;
        s = (d == 8) ? 11 : 10;
        q = n >>> s;
        r = n - (q <<< s);
        if (r > (1 << (s - 1)) || (r == (1 << (s - 1)) && q[0])) begin
            q++;
        end
        q = (q > 16383) ? 16383 : ((q < -16384) ? -16384 : q);
        return q[14:0];
    endfunction
    task automatic check_paths(input int xa, xb, ka, kb, d);
        int n;
        wait_out(3, n);
        check("a_iq", 32'({expect_out(xa, cosv[ka], d), expect_out(xa, sinv[ka], d)}), 32'({a_i, a_q}));
        check("b_iq", 32'({expect_out(xb, cosv[kb], d), expect_out(xb, sinv[kb], d)}), 32'({b_i, b_q}));
    endtask
    initial begin
        void'($urandom(66));
        repeat (5) @(posedge i_clk);
        i_arst_n <= 1'b1;
        wb(0, `DDC_OFS_CTRL, 0);
        check("ctrl_reset", 0, rdat);
        wb(1, 8'h50, 32'hFFFFFFFF);
        wb(0, 8'h50, 0);
        check("unmapped", 0, rdat);
        wb(1, `DDC_OFS_RDIV, 32'hFFFFBEEF);
        wb(0, `DDC_OFS_RDIV, 0);
        check("rdiv", 32'h0000BEEF, rdat);
        wb(1, `DDC_OFS_CTRL, 1);
        repeat (4) @(posedge i_clk);
        repeat (8) begin
            prev = {adc_b, adc_a};
            @(posedge i_clk);
            check("bypass", 32'(prev), 32'({byp_b, byp_a}));
        end
        check("bypass_valid", 1, 32'(byp_v));
        hold <= 1'b1;
        lvl_a <= 12'($urandom);
        lvl_b <= 12'($urandom);
        for (int k = 0; k < 4; k++) begin
            wb(1, 8'(`DDC_OFS_PHASE_BASE + 4 * k), 32'(k << 14));
            wb(1, 8'(`DDC_OFS_PHASE_BASE + 16 + 4 * k), 32'(k << 14));
        end
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 4; k++) begin
                pins_a <= 2'(s ? k : 3 - k);
                pins_b <= 2'(s ? 3 - k : k);
                c = 'h200 | (s ? (4 | ((3 - k) << 4) | (k << 6)) : ((k << 4) | ((3 - k) << 6)));
                wb(1, `DDC_OFS_CTRL, 32'(c));
                check_paths($signed(lvl_a), $signed(lvl_b), k, 3 - k, 4);
                wb(0, `DDC_OFS_STATUS, 0);
                check("status", 32'(k + 4 * (3 - k)), 32'(rdat[3:0]));
            end
        end
        wait_out(1, g);
        wait_out(1, g);
        check("dec4_gap", 4, 32'(g));
        lvl_a <= 12'h080;
        lvl_b <= 12'h180;
        wb(1, `DDC_OFS_CTRL, 32'h500);
        check_paths(384, 128, 0, 0, 8);
        wait_out(1, g);
        check("dec8_gap", 8, 32'(g));
        lvl_a <= 12'hF80;
        wb(1, `DDC_OFS_CTRL, 0);
        check_paths(-128, -128, 0, 0, 4);
        for (int f = 0; f < 3; f++) begin
            wb(1, `DDC_OFS_FREQ_BASE, frq[f]);
            wb(1, 8'(`DDC_OFS_FREQ_BASE + 16), frq[f]);
            check_paths(-128, -128, 4, 4, 4);
        end
        rnd = $urandom;
        wb(1, 8'h28, rnd);
        wb(0, 8'h28, 0);
        check("freq_b2", rnd, rdat);
        wb(1, `DDC_OFS_CTRL, 2);
        repeat (4) @(posedge i_clk);
        bv = 0;
        repeat (40) begin
            @(posedge i_clk);
            bv += (b_v !== 1'b0);
        end
        check("single_b_valid", 0, 32'(bv));
        i_arst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        check("reset_out", 0, 32'({a_i, a_q, byp_v, a_v}));
        i_arst_n <= 1'b1;
        wb(0, `DDC_OFS_CTRL, 0);
        check("ctrl_rereset", 0, rdat);
        tally_and_finish();
    end
endmodule
